// File: lmpc_pkg.sv
// Constants, register map and operation codes for the legacy mode protection checker
package lmpc_pkg;

  // ==========================================================================
  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_SEG = 8'h08;
  localparam logic [7:0] REG_OFFSET = 8'h0C;
  localparam logic [7:0] REG_PORT = 8'h10;
  localparam logic [7:0] REG_RESULT = 8'h14;
  localparam logic [7:0] REG_ADDR_OUT = 8'h18;
  localparam logic [7:0] REG_PAGE_DIR = 8'h1C;
  localparam logic [7:0] REG_TASK_LIMIT = 8'h20;
  localparam logic [7:0] REG_TASK_INDEX = 8'h24;
  localparam logic [7:0] REG_TASK_DATA = 8'h28;
  localparam logic [7:0] REG_PAGE_INDEX = 8'h2C;
  localparam logic [7:0] REG_PAGE_DATA = 8'h30;
  localparam logic [7:0] REG_NEW_FLAGS = 8'h34;
  localparam logic [7:0] REG_SAVED_FLAGS = 8'h38;
  localparam logic [7:0] REG_PUSHED_BASE = 8'h40;
  localparam logic [7:0] REG_SEGREG_BASE = 8'h50;
  localparam logic [3:0] SEG_GROUP_SEL = 4'h4;
  localparam logic [3:0] PUSH_GROUP_SEL = 4'h4;

  // ==========================================================================
  // Control register fields
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_PROT_BIT = 1;
  localparam int CTRL_PAGING_BIT = 2;
  localparam int CTRL_PRIV_LO = 4;
  localparam int CTRL_IOPRIV_LO = 6;

  // ==========================================================================
  // Command register and result fields
  localparam int CMD_SIZE_LO = 4;
  localparam int RES_VEC_LO = 8;
  localparam int RES_ISSUE_BIT = 16;

  // ==========================================================================
  // Architectural constants
  localparam int FLAGS_MODE_BIT = 17;
  localparam int SEG_SHIFT = 4;
  localparam logic [31:0] OFFSET_LIMIT = 32'h0000_FFFF;
  localparam logic [7:0] VEC_GP = 8'h0D;
  localparam logic [7:0] VEC_UD = 8'h06;
  localparam logic [7:0] VEC_NONE = 8'h00;
  localparam logic [1:0] PRIV_USER = 2'h3;
  localparam logic [1:0] PRIV_HOST = 2'h0;
  localparam logic [15:0] TASK_MAP_PTR_OFF = 16'h0066;
  localparam logic [15:0] TASK_PAGE_DIR_OFF = 16'h001C;
  localparam logic [15:0] NULL_SELECTOR = 16'h0000;
  localparam logic [7:0] DENY_BYTE = 8'hFF;
  localparam logic [31:0] TASK_LIMIT_RST = 32'h0000_0000;

  // ==========================================================================
  // Operation classes, written to the command register
  typedef enum logic [3:0] {
    OP_MEM = 4'h0,
    OP_IO = 4'h1,
    OP_IO_STRING = 4'h2,
    OP_SET_IF = 4'h3,
    OP_CLR_IF = 4'h4,
    OP_PUSH_FLAGS = 4'h5,
    OP_POP_FLAGS = 4'h6,
    OP_INT_RETURN = 4'h7,
    OP_INT_N = 4'h8,
    OP_BREAKPOINT = 4'h9,
    OP_INT_OVERFLOW = 4'hA,
    OP_BOUND = 4'hB,
    OP_PRIVILEGED = 4'hC,
    OP_PROT_ONLY = 4'hD,
    OP_TASK_SWITCH = 4'hE,
    OP_INTERRUPT = 4'hF
  } lmpc_op_e;

endpackage : lmpc_pkg

// File: lmpc_top.sv
// Legacy mode protection checker with Avalon-MM register access
`timescale 1ns/100ps

module lmpc_top
  import lmpc_pkg::*;
#(
  parameter int TASK_WORDS = 64,
  parameter int PAGES = 256
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Check outcome
  output logic op_issue,
  output logic op_fault,
  output logic [7:0] fault_vector
);

  localparam int TASK_BYTES = TASK_WORDS * 4;
  localparam int TW = $clog2(TASK_WORDS);
  localparam int PW = $clog2(PAGES);

  // ==========================================================================
  // Reset release
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ==========================================================================
  // State
  logic mode_q, prot_q, paging_q;
  logic [1:0] priv_q, iopriv_q;
  logic [3:0] op_q;
  logic [1:0] size_q;
  logic [15:0] seg_q, port_q;
  logic [31:0] offset_q, limit_q, new_flags_q, saved_flags_q, page_dir_q, addr_out_q;
  logic [TW-1:0] task_idx_q;
  logic [PW-1:0] page_idx_q;
  logic [31:0] task_mem_q [TASK_WORDS];
  logic [19:0] page_mem_q [PAGES];
  logic [15:0] segreg_q [4];
  logic [31:0] pushed_q [4];
  logic ack_q;
  logic [31:0] rdata_q, rdata_d;
  logic issue_q, fault_q, res_issue_q, res_fault_q;
  logic [7:0] vec_q;

  // ==========================================================================
  // Bus decode, one wait state per access
  wire req = avs_read | avs_write;
  wire wr_done = avs_write & ack_q;
  wire [7:0] word_addr = {avs_address[7:2], 2'b00};
  wire wr_ctrl = wr_done & (word_addr == REG_CTRL);
  wire wr_cmd = wr_done & (word_addr == REG_CMD);
  wire wr_seg_grp = wr_done & (word_addr[7:4] == SEG_GROUP_SEL + 4'h1);
  wire [1:0] grp_sel = avs_address[3:2];
  wire [3:0] cmd_op = avs_writedata[3:0];
  wire [1:0] cmd_size = avs_writedata[CMD_SIZE_LO +: 2];
  assign avs_waitrequest = req & ~ack_q;

  // ==========================================================================
  // Address forming and paging
  wire [20:0] lin_addr = {1'b0, seg_q, 4'h0} + {5'h00, offset_q[15:0]};
  wire [PW-1:0] lin_page = lin_addr[12 +: PW];
  wire page_mapped = paging_q & ~lin_addr[20];
  wire [31:0] legacy_addr = page_mapped ?
    {page_mem_q[lin_page], lin_addr[11:0]} : {11'h000, lin_addr};
  wire [31:0] mem_addr = (mode_q | ~prot_q) ? legacy_addr : offset_q;
  wire offset_over = offset_q > OFFSET_LIMIT;

  // ==========================================================================
  // Privilege terms
  wire [1:0] priv_eff = mode_q ? PRIV_USER : priv_q;
  wire iopriv_deny = prot_q & (priv_eff > iopriv_q);
  wire priv_deny = prot_q & (priv_eff != PRIV_HOST);

  // ==========================================================================
  // Port permission bitmap
  function automatic logic [7:0] task_byte(input logic [31:0] idx,
                                           input logic [31:0] lim,
                                           input logic [31:0] mem [TASK_WORDS]);
    logic [31:0] w;
    w = 32'h0;
    task_byte = DENY_BYTE;
    if (idx <= lim && idx < TASK_BYTES)
    begin
      w = mem[idx[TW+1:2]];
      task_byte = w[{idx[1:0], 3'b000} +: 8];
    end
  endfunction : task_byte

  wire [31:0] map_ptr_idx = {16'h0000, TASK_MAP_PTR_OFF};
  wire [7:0] ptr_lo = task_byte(map_ptr_idx, limit_q, task_mem_q);
  wire [7:0] ptr_hi = task_byte(map_ptr_idx + 32'h1, limit_q, task_mem_q);
  wire [15:0] map_base = {ptr_hi, ptr_lo};
  wire [31:0] map_byte0 = {16'h0000, map_base} + {19'h00000, port_q[15:3]};
  wire [7:0] map_lo = task_byte(map_byte0, limit_q, task_mem_q);
  wire [7:0] map_hi = task_byte(map_byte0 + 32'h1, limit_q, task_mem_q);
  wire [15:0] map_pair = {map_hi, map_lo} >> port_q[2:0];
  wire [3:0] size_mask = (size_q == 2'd0) ? 4'h1 : (size_q == 2'd1) ? 4'h3 : 4'hF;
  wire map_deny = |(map_pair[3:0] & size_mask);

  // ==========================================================================
  // Fault decision for the latched command, settled before issue
  logic [7:0] vec_d;
  always_comb
  begin
    vec_d = VEC_NONE;
    unique case (lmpc_op_e'(op_q))
      OP_MEM:
        if ((mode_q | ~prot_q) && offset_over) vec_d = VEC_GP;
      OP_IO, OP_IO_STRING:
        if (mode_q) vec_d = map_deny ? VEC_GP : VEC_NONE;
        else if (iopriv_deny) vec_d = VEC_GP;
      OP_SET_IF, OP_CLR_IF:
        if (iopriv_deny) vec_d = VEC_GP;
      OP_PUSH_FLAGS, OP_POP_FLAGS, OP_INT_RETURN, OP_INT_N:
        if (mode_q && iopriv_deny) vec_d = VEC_GP;
      OP_BREAKPOINT, OP_INT_OVERFLOW, OP_BOUND:
        vec_d = VEC_NONE;
      OP_PRIVILEGED:
        if (priv_deny) vec_d = VEC_GP;
      OP_PROT_ONLY:
        if (mode_q | ~prot_q) vec_d = VEC_UD;
      OP_TASK_SWITCH, OP_INTERRUPT:
        vec_d = VEC_NONE;
    endcase
  end
  wire chk_fault = vec_d != VEC_NONE;

  // Command evaluation runs one cycle after the write, so state is untouched on a fault
  logic eval_q;
  wire eval_ok = eval_q & ~chk_fault;
  wire do_task = eval_ok & prot_q & (op_q == OP_TASK_SWITCH);
  wire do_interrupt_return_op = eval_ok & prot_q & ~mode_q & (priv_q == PRIV_HOST) & (op_q == OP_INT_RETURN);
  wire do_intr = eval_ok & mode_q & (op_q == OP_INTERRUPT);
  wire [31:0] pdir_idx = {16'h0000, TASK_PAGE_DIR_OFF};

  // ==========================================================================
  // Bus handshake and command latch
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      ack_q <= 1'b0;
      eval_q <= 1'b0;
      op_q <= OP_BREAKPOINT;
      size_q <= 2'h0;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      eval_q <= wr_cmd;
      if (wr_cmd)
      begin
        op_q <= cmd_op;
        size_q <= cmd_size;
      end
    end
  end

  // ==========================================================================
  // Operands and tables
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      seg_q <= 16'h0000;
      offset_q <= 32'h0;
      port_q <= 16'h0000;
      limit_q <= TASK_LIMIT_RST;
      task_idx_q <= '0;
      page_idx_q <= '0;
      new_flags_q <= 32'h0;
    end
    else if (wr_done)
    begin
      if (word_addr == REG_SEG) seg_q <= avs_writedata[15:0];
      if (word_addr == REG_OFFSET) offset_q <= avs_writedata;
      if (word_addr == REG_PORT) port_q <= avs_writedata[15:0];
      if (word_addr == REG_TASK_LIMIT) limit_q <= avs_writedata;
      if (word_addr == REG_TASK_INDEX) task_idx_q <= avs_writedata[TW-1:0];
      if (word_addr == REG_PAGE_INDEX) page_idx_q <= avs_writedata[PW-1:0];
      if (word_addr == REG_NEW_FLAGS) new_flags_q <= avs_writedata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (wr_done && word_addr == REG_TASK_DATA) task_mem_q[task_idx_q] <= avs_writedata;
    if (wr_done && word_addr == REG_PAGE_DATA) page_mem_q[page_idx_q] <= avs_writedata[19:0];
  end

  // ==========================================================================
  // Mode, privilege and flags state
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      mode_q <= 1'b0;
      prot_q <= 1'b0;
      paging_q <= 1'b0;
      priv_q <= PRIV_HOST;
      iopriv_q <= PRIV_HOST;
      saved_flags_q <= 32'h0;
      page_dir_q <= 32'h0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        // Mode flag is not software writable here
        prot_q <= avs_writedata[CTRL_PROT_BIT];
        paging_q <= avs_writedata[CTRL_PAGING_BIT];
        priv_q <= avs_writedata[CTRL_PRIV_LO +: 2];
        iopriv_q <= avs_writedata[CTRL_IOPRIV_LO +: 2];
      end
      if (do_task)
      begin
        mode_q <= new_flags_q[FLAGS_MODE_BIT];
        page_dir_q <= {task_byte(pdir_idx + 32'h3, limit_q, task_mem_q),
                       task_byte(pdir_idx + 32'h2, limit_q, task_mem_q),
                       task_byte(pdir_idx + 32'h1, limit_q, task_mem_q),
                       task_byte(pdir_idx, limit_q, task_mem_q)};
      end
      else if (do_interrupt_return_op)
        mode_q <= new_flags_q[FLAGS_MODE_BIT];
      else if (do_intr)
      begin
        mode_q <= 1'b0;
        priv_q <= PRIV_HOST;
        saved_flags_q <= new_flags_q | (32'h1 << FLAGS_MODE_BIT);
      end
    end
  end

  // ==========================================================================
  // Data segment registers, order gs fs ds es at indices 0 to 3
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_seg
      always_ff @(posedge ref_clk or negedge rst_sync_q)
      begin
        if (!rst_sync_q)
        begin
          segreg_q[g] <= NULL_SELECTOR;
          pushed_q[g] <= 32'h0;
        end
        else if (do_intr)
        begin
          pushed_q[g] <= {16'h0000, segreg_q[g]};
          segreg_q[g] <= NULL_SELECTOR;
        end
        else if (wr_seg_grp && grp_sel == 2'(g))
          segreg_q[g] <= avs_writedata[15:0];
      end
    end
  endgenerate

  // ==========================================================================
  // Outcome and read data
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      issue_q <= 1'b0;
      fault_q <= 1'b0;
      vec_q <= VEC_NONE;
      res_issue_q <= 1'b0;
      res_fault_q <= 1'b0;
      addr_out_q <= 32'h0;
      rdata_q <= 32'h0;
    end
    else
    begin
      issue_q <= eval_ok;
      fault_q <= eval_q & chk_fault;
      if (eval_q)
      begin
        vec_q <= vec_d;
        // Result bits stand until the next command, unlike the pulses
        res_issue_q <= ~chk_fault;
        res_fault_q <= chk_fault;
        addr_out_q <= mem_addr;
      end
      rdata_q <= rdata_d;
    end
  end

  always_comb
  begin
    rdata_d = 32'h0;
    if (word_addr[7:4] == PUSH_GROUP_SEL)
      rdata_d = pushed_q[grp_sel];
    else if (word_addr[7:4] == SEG_GROUP_SEL + 4'h1)
      rdata_d = {16'h0000, segreg_q[grp_sel]};
    else if (word_addr == REG_CTRL)
      rdata_d = {24'h0, iopriv_q, priv_q, 1'b0, paging_q, prot_q, mode_q};
    else if (word_addr == REG_CMD)
      rdata_d = {26'h0, size_q, op_q};
    else if (word_addr == REG_SEG) rdata_d = {16'h0000, seg_q};
    else if (word_addr == REG_OFFSET) rdata_d = offset_q;
    else if (word_addr == REG_PORT) rdata_d = {16'h0000, port_q};
    else if (word_addr == REG_RESULT)
      rdata_d = {15'h0, res_issue_q, vec_q, 7'h0, res_fault_q};
    else if (word_addr == REG_ADDR_OUT) rdata_d = addr_out_q;
    else if (word_addr == REG_PAGE_DIR) rdata_d = page_dir_q;
    else if (word_addr == REG_TASK_LIMIT) rdata_d = limit_q;
    else if (word_addr == REG_TASK_DATA) rdata_d = task_mem_q[task_idx_q];
    else if (word_addr == REG_PAGE_DATA) rdata_d = {12'h000, page_mem_q[page_idx_q]};
    else if (word_addr == REG_NEW_FLAGS) rdata_d = new_flags_q;
    else if (word_addr == REG_SAVED_FLAGS) rdata_d = saved_flags_q;
  end

  // Read data is captured one edge early so it stands when waitrequest drops
  assign avs_readdata = rdata_q;
  assign op_issue = issue_q;
  assign op_fault = fault_q;
  assign fault_vector = vec_q;

endmodule : lmpc_top

// File: lmpc_monitor.sv
// Port-level assertions for the legacy mode protection checker
`timescale 1ns/100ps
module lmpc_monitor
  import lmpc_pkg::*;
#(
  parameter int TASK_WORDS = 64,
  parameter int PAGES = 256
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Check outcome
  input wire logic op_issue,
  input wire logic op_fault,
  input wire logic [7:0] fault_vector
);
  // ==========================================================================
  // Helpers
  wire logic req = avs_read | avs_write;
  wire logic cmd_done = avs_write & ~avs_waitrequest & (avs_address[7:2] == REG_CMD[7:2]);
  wire logic any_out = op_issue | op_fault;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Assertions
  bus_wait_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held beyond one cycle");
  bus_idle_a: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest high while idle");
  outcome_excl_a: assert property (!(op_issue && op_fault))
    else $error("issue and fault together");
  cmd_answer_a: assert property (cmd_done |-> ##2 (op_issue ^ op_fault))
    else $error("command gave no outcome");
  no_stray_a: assert property (any_out |-> $past(cmd_done, 2))
    else $error("outcome without command");
  pulse_single_a: assert property (any_out |=> !any_out)
    else $error("outcome pulse too long");
  fault_code_a: assert property (op_fault |-> fault_vector == VEC_GP || fault_vector == VEC_UD)
    else $error("bad fault vector");
  issue_code_a: assert property (op_issue |-> fault_vector == VEC_NONE)
    else $error("vector set on issue");
  vector_hold_a: assert property ($changed(fault_vector) |-> any_out)
    else $error("vector moved between commands");
endmodule : lmpc_monitor

bind lmpc_top lmpc_monitor #(.TASK_WORDS(TASK_WORDS), .PAGES(PAGES)) u_mon (.ref_clk, .rst_n,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .op_issue, .op_fault, .fault_vector);

// File: lmpc_test.sv
// Self-checking bench for the legacy mode protection checker
`timescale 1ns/100ps
module lmpc_test
  import lmpc_pkg::*;
();
  // ==========================================================================
  // Stimulus and observed signals
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest;
  wire logic op_issue;
  wire logic op_fault;
  wire logic [7:0] fault_vector;
  logic [31:0] rd;
  int err_total = 0;
  int num_checks = 0;

  lmpc_top u_dut (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .op_issue, .op_fault, .fault_vector);

  initial
    forever #2 ref_clk = ~ref_clk;

  // ==========================================================================
  // Shared tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Request held until waitrequest is seen low at a rising edge, data taken there
  task av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0 && n++ < 50);
    if (n >= 50)
    begin
      err_total++;
      $display("[FAIL] %0t bus wait timed out", $time);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av

  task wr(input logic [7:0] a, input logic [31:0] d);
    av(1'b1, a, d);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc

  task ctrl(input logic [1:0] io_lvl, input logic [1:0] run_lvl, input logic pg, input logic pr);
    wr(REG_CTRL, {24'h0, io_lvl, run_lvl, 1'b0, pg, pr, 1'b0});
  endtask : ctrl

  // Result is read only after the update edge has passed
  task cmd(input lmpc_op_e op, input logic [1:0] sz, input logic f, input logic [7:0] v);
    wr(REG_CMD, {26'h0, sz, op});
    repeat (3) @(posedge ref_clk);
    rdc(REG_RESULT, f ? {16'h0, v, 8'h01} : 32'h0001_0000);
    chk({24'h0, fault_vector}, {24'h0, f ? v : VEC_NONE});
  endtask : cmd

  task io(input logic [15:0] p, input logic [1:0] sz, input logic f);
    wr(REG_PORT, {16'h0, p});
    cmd(OP_IO, sz, f, f ? VEC_GP : VEC_NONE);
  endtask : io

  task tseg_wr(input logic [31:0] idx, input logic [31:0] d);
    wr(REG_TASK_INDEX, idx);
    wr(REG_TASK_DATA, d);
  endtask : tseg_wr

  // ==========================================================================
  // Scenarios
  task t_real;
    ctrl(2'h0, 2'h0, 1'b0, 1'b0);
    cmd(OP_PROT_ONLY, 2'h0, 1'b1, VEC_UD);
    cmd(OP_PRIVILEGED, 2'h0, 1'b0, VEC_NONE);
    $display("t_real done");
  endtask : t_real

  task t_prot;
    ctrl(2'h0, PRIV_USER, 1'b0, 1'b1);
    for (int k = 1; k <= 4; k++)
      cmd(lmpc_op_e'(k), 2'h0, 1'b1, VEC_GP);
    for (int k = 9; k <= 11; k++)
      cmd(lmpc_op_e'(k), 2'h0, 1'b0, VEC_NONE);
    cmd(OP_PUSH_FLAGS, 2'h0, 1'b0, VEC_NONE);
    cmd(OP_PRIVILEGED, 2'h0, 1'b1, VEC_GP);
    cmd(OP_PROT_ONLY, 2'h0, 1'b0, VEC_NONE);
    ctrl(2'h3, PRIV_USER, 1'b0, 1'b1);
    cmd(OP_SET_IF, 2'h0, 1'b0, VEC_NONE);
    wr(REG_NEW_FLAGS, 32'h0002_0000);
    wr(REG_CMD, {28'h0, OP_INT_RETURN});
    repeat (3) @(posedge ref_clk);
    rdc(REG_CTRL, 32'h0000_00F2);
    $display("t_prot done");
  endtask : t_prot

  task t_enter;
    ctrl(2'h0, PRIV_HOST, 1'b0, 1'b1);
    wr(REG_TASK_LIMIT, 32'h0000_0082);
    tseg_wr(32'd7, 32'h0005_A000);
    tseg_wr(32'd25, 32'h0080_0000);
    tseg_wr(32'd32, 32'h00FF_0002);
    wr(REG_NEW_FLAGS, 32'h0002_0000);
    cmd(OP_TASK_SWITCH, 2'h0, 1'b0, VEC_NONE);
    rdc(REG_PAGE_DIR, 32'h0005_A000);
    av(1'b0, REG_CTRL, 32'h0);
    chk({31'h0, rd[CTRL_MODE_BIT]}, 32'h1);
    $display("t_enter done");
  endtask : t_enter

  task t_legacy;
    ctrl(2'h0, PRIV_USER, 1'b0, 1'b1);
    cmd(OP_PRIVILEGED, 2'h0, 1'b1, VEC_GP);
    cmd(OP_PROT_ONLY, 2'h0, 1'b1, VEC_UD);
    for (int k = 3; k <= 8; k++)
      cmd(lmpc_op_e'(k), 2'h0, 1'b1, VEC_GP);
    for (int k = 9; k <= 11; k++)
      cmd(lmpc_op_e'(k), 2'h0, 1'b0, VEC_NONE);
    ctrl(2'h3, PRIV_USER, 1'b0, 1'b1);
    cmd(OP_INT_N, 2'h0, 1'b0, VEC_NONE);
    $display("t_legacy done");
  endtask : t_legacy

  task t_addr;
    wr(REG_SEG, 32'h0000_1234);
    wr(REG_OFFSET, 32'h0000_0010);
    cmd(OP_MEM, 2'h0, 1'b0, VEC_NONE);
    rdc(REG_ADDR_OUT, 32'h0001_2350);
    wr(REG_OFFSET, 32'h0000_FFFF);
    cmd(OP_MEM, 2'h0, 1'b0, VEC_NONE);
    wr(REG_OFFSET, 32'h0001_0000);
    cmd(OP_MEM, 2'h0, 1'b1, VEC_GP);
    wr(REG_PAGE_INDEX, 32'h0000_0012);
    wr(REG_PAGE_DATA, 32'h000A_BCDE);
    ctrl(2'h0, PRIV_USER, 1'b1, 1'b1);
    wr(REG_OFFSET, 32'h0000_0010);
    cmd(OP_MEM, 2'h0, 1'b0, VEC_NONE);
    rdc(REG_ADDR_OUT, 32'hABCD_E350);
    $display("t_addr done");
  endtask : t_addr

  // Low privilege on purpose: ports must bypass the privilege check
  task t_bitmap;
    io(16'h0000, 2'h0, 1'b0);
    io(16'h0001, 2'h0, 1'b1);
    io(16'h0000, 2'h1, 1'b1);
    io(16'h0008, 2'h2, 1'b0);
    io(16'h000E, 2'h2, 1'b1);
    io(16'h0017, 2'h0, 1'b1);
    wr(REG_TASK_LIMIT, 32'h0000_0080);
    io(16'h0008, 2'h0, 1'b1);
    io(16'h0000, 2'h0, 1'b0);
    wr(REG_TASK_LIMIT, 32'h0000_0082);
    tseg_wr(32'd25, 32'h00F0_0000);
    io(16'h0008, 2'h0, 1'b1);
    $display("t_bitmap done");
  endtask : t_bitmap

  task t_intr;
    for (int k = 0; k < 4; k++)
      wr(REG_SEGREG_BASE + 8'(4 * k), 32'h1111 * (k + 1));
    wr(REG_NEW_FLAGS, 32'h0000_0202);
    cmd(OP_INTERRUPT, 2'h0, 1'b0, VEC_NONE);
    rdc(REG_CTRL, 32'h0000_0006);
    rdc(REG_SAVED_FLAGS, 32'h0002_0202);
    for (int k = 0; k < 4; k++)
    begin
      rdc(REG_PUSHED_BASE + 8'(4 * k), 32'h1111 * (k + 1));
      rdc(REG_SEGREG_BASE + 8'(4 * k), {16'h0, NULL_SELECTOR});
    end
    $display("t_intr done");
  endtask : t_intr

  // ==========================================================================
  // Run control
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_real;
    t_prot;
    t_enter;
    t_legacy;
    t_addr;
    t_bitmap;
    t_intr;
    print_verdict;
  end

  // Roughly ninety times the expected run
  initial
  begin
    #200000;
    err_total++;
    print_verdict;
  end
endmodule : lmpc_test
